/* File: core/uhp_defines.svh */
// register offsets, field positions and limits of the pipe status block
// Summary of operation
// - interrupt pipes use the poll field as longest poll interval; others ignore it
// - alloc ok sets on successful allocation, clears when pipe disabled or on rst_i
// - overflow flag sets on oversize receive; software clears, writing one ignored
// - iso or interrupt OUT pipe with empty bank sends zero-length packet, flags underflow
// - toggle indicator: 00 DATA0, 01 DATA1; OUT next toggle, IN last received
// - busy bank count 00 none, 01 one, 10 two banks busy
// - counted mode issues count plus one IN requests then freezes; infinite ignores count
// - two-bit error counter increments per pipe error, freezes pipe at three
// - crc, timeout, pid, data pid, bad toggle flags; software clears only
// - OUT/SETUP: fifo control sets with bank ready when bank frees; clear sends bank
// - IN: fifo control sets with in received on new message; clear frees bank
// - nak received flag sets on NAK, interrupts when enabled, software clears
// - rw allowed while fifo accessible; cleared on full, empty, stall or pipe error
// - pipe error flag follows error sources, interrupts when enabled
// - setup and out bank ready flags set on free bank, own enables, software clears
// - stall on non-iso pipes sets stall flag and freezes pipe, interrupts when enabled
// - on iso pipes stall position flags crc error, gated by setup enable
// - in received flag sets on stored message, interrupts when enabled
// - one flow error enable gates overflow and underflow; other flags own enables
// - each data register access moves one byte to or from the selected pipe fifo
// - 11-bit byte count: OUT up on write, down on send; IN up on receive, down on read
// - seven-bit summary, one bit per pipe with enabled flag raised; bit 7 zero
// - freeze set on unconfigured pipe, stall on a non-iso pipe, pipe error or exhausted IN requests
`ifndef UHP_DEFINES_SVH
`define UHP_DEFINES_SVH
// ==========================================================
// word offsets, matched against adr_i[7:2]
`define UHP_OFS_PIPE_SEL 6'h00
`define UHP_OFS_PIPE_CTL 6'h01
`define UHP_OFS_PIPE_CFG 6'h02
`define UHP_OFS_POLL 6'h03
`define UHP_OFS_STATE 6'h04
`define UHP_OFS_IN_REQUEST_COUNT_FIELD 6'h05
`define UHP_OFS_ERR 6'h06
`define UHP_OFS_EVT 6'h07
`define UHP_OFS_IEN 6'h08
`define UHP_OFS_DATA 6'h09
`define UHP_OFS_BCH 6'h0a
`define UHP_OFS_BCL 6'h0b
`define UHP_OFS_SUM 6'h0c
// ==========================================================
// field positions
`define UHP_CTL_EN 0
`define UHP_CTL_INF 5
`define UHP_CTL_FRZ 6
`define UHP_EV_FCON 7
`define UHP_EV_NAK 6
`define UHP_EV_PERR 4
`define UHP_EV_STP 3
`define UHP_EV_OUT 2
`define UHP_EV_STL 1
`define UHP_EV_RXIN 0
`define UHP_IEN_FLOW 7
`define UHP_ERR_MAX 2'h3
`define UHP_BUSY_MAX 2'h2
`define UHP_NUM_PIPES 7
`endif

/* File: core/uhp_pkg.sv */
// types of the pipe status block
package uhp_pkg;
  typedef enum logic [1:0] {
    UHP_CONTROL = 2'h0,
    UHP_ISO = 2'h1,
    UHP_BULK = 2'h2,
    UHP_INTR = 2'h3
  } uhp_ptype_t;
  typedef enum logic [1:0] {
    UHP_SETUP = 2'h0,
    UHP_IN = 2'h1,
    UHP_OUT = 2'h2,
    UHP_TOK_RSVD = 2'h3
  } uhp_token_t;
endpackage

/* File: core/uhp_pipe_status.sv */
// per-pipe status, error, event flags and fifo port of a usb host controller
`timescale 1ns/100ps
`include "uhp_defines.svh"
module uhp_pipe_status #(
  parameter int MAX_BYTES = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [2:0] evt_pipe_i,
  input wire logic ev_alloc_ok_i,
  input wire logic ev_overflow_i,
  input wire logic ev_tx_req_i,
  input wire logic ev_toggle_i,
  input wire logic ev_toggle_val_i,
  input wire logic ev_bank_filled_i,
  input wire logic ev_bank_sent_i,
  input wire logic ev_in_done_i,
  input wire logic ev_nak_i,
  input wire logic ev_stall_i,
  input wire logic ev_crc_error_flag_i,
  input wire logic ev_timeout_i,
  input wire logic ev_pid_i,
  input wire logic ev_data_pid_error_flag_i,
  input wire logic ev_badtgl_i,
  input wire logic ev_byte_rx_i,
  input wire logic ev_byte_tx_i,
  input wire logic [7:0] fifo_rdata_i,
  output logic fifo_wr_o,
  output logic fifo_rd_o,
  output logic [7:0] fifo_wdata_o,
  output logic [2:0] fifo_pipe_o,
  output logic zlp_o,
  output logic [6:0] freeze_o,
  output logic [7:0] poll_ms_o
);
  localparam int NP = `UHP_NUM_PIPES;

  // ==========================================================
  // wishbone slave
  logic ack_q;
  logic [31:0] dat_q;
  logic [2:0] sel_pipe_q;
  logic req;
  logic wr;
  logic rd;
  logic [5:0] ofs;
  assign req = cyc_i & stb_i;
  assign ofs = adr_i[7:2];
  // write and read side effects happen only on the acknowledging edge
  assign wr = req & ack_q & we_i & sel_i[0];
  assign rd = req & ack_q & ~we_i;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  function automatic logic hit(input logic [5:0] o, input logic [5:0] t);
    hit = (o == t);
  endfunction

  // one wait state, ack dropped the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // pipe number selects all indexed registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_pipe_q <= 3'h0;
    end else if (wr && hit(ofs, `UHP_OFS_PIPE_SEL)) begin
      sel_pipe_q <= dat_i[2:0];
    end
  end

  // ==========================================================
  // per-pipe state
  logic [7:0] rd_ctl [NP];
  logic [7:0] rd_cfg [NP];
  logic [7:0] rd_poll [NP];
  logic [7:0] rd_state [NP];
  logic [7:0] rd_in_request_count_field [NP];
  logic [7:0] rd_err [NP];
  logic [7:0] rd_evt [NP];
  logic [7:0] rd_ien [NP];
  logic [10:0] rd_bc [NP];
  logic [7:0] poll_eff [NP];
  logic [NP-1:0] zlp_w;
  logic [NP-1:0] sum_w;
  logic [NP-1:0] frz_w;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : pipe
      logic en_q, frz_q, inf_q, aok_q, ovf_q, udf_q, tgl_q;
      logic fcon_q, nak_q, stp_q, out_q, stl_q, rxin_q;
      logic [1:0] typ_q, tok_q, busy_q, ecnt_q;
      logic [7:0] poll_q, in_request_count_field_q, ien_q;
      logic [4:0] err_q;
      logic [10:0] bc_q;
      logic me, sw, is_out, is_in, is_iso, perr, any_err, rw_allowed, pwr, prd;
      logic fcon_clr, in_last, zlp, evt_wr;
      assign me = (evt_pipe_i == 3'(g));
      assign sw = (sel_pipe_q == 3'(g));
      assign is_in = (tok_q == uhp_pkg::UHP_IN);
      assign is_out = ~is_in;
      assign is_iso = (typ_q == uhp_pkg::UHP_ISO);
      assign any_err = me & (ev_crc_error_flag_i | ev_timeout_i | ev_pid_i | ev_data_pid_error_flag_i | ev_badtgl_i);
      assign perr = |err_q;
      // bank release by software clearing fifo control
      assign fcon_clr = wr & sw & hit(ofs, `UHP_OFS_EVT) & ~dat_i[`UHP_EV_FCON] & fcon_q;
      assign pwr = wr & sw & hit(ofs, `UHP_OFS_DATA);
      assign prd = rd & sw & hit(ofs, `UHP_OFS_DATA);
      // software write to this pipe's event flags, kept out of the clocked process
      assign evt_wr = wr & sw & hit(ofs, `UHP_OFS_EVT);
      assign in_last = me & ev_in_done_i & ~inf_q & (in_request_count_field_q == 8'h00);
      assign zlp = me & ev_tx_req_i & is_out & busy_q == 2'h0
                   & (typ_q == uhp_pkg::UHP_ISO || typ_q == uhp_pkg::UHP_INTR);

      // control and configuration
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          en_q <= 1'b0;
          inf_q <= 1'b0;
          typ_q <= 2'h0;
          tok_q <= 2'h0;
          poll_q <= 8'h00;
        end else if (wr && sw) begin
          if (hit(ofs, `UHP_OFS_PIPE_CTL)) begin
            en_q <= dat_i[`UHP_CTL_EN];
            inf_q <= dat_i[`UHP_CTL_INF];
          end
          if (hit(ofs, `UHP_OFS_PIPE_CFG)) begin
            typ_q <= dat_i[7:6];
            tok_q <= dat_i[5:4];
          end
          if (hit(ofs, `UHP_OFS_POLL)) begin
            poll_q <= dat_i[7:0];
          end
        end
      end

      // freeze: hardware sets win over a software clear
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          frz_q <= 1'b1;
        end else if (~aok_q || (me && (ev_stall_i && !is_iso)) || any_err
                     || in_last
                     || (ecnt_q == `UHP_ERR_MAX)) begin
          frz_q <= 1'b1;
        end else if (wr && sw && hit(ofs, `UHP_OFS_PIPE_CTL)) begin
          frz_q <= dat_i[`UHP_CTL_FRZ] | (dat_i[`UHP_CTL_EN] & ~en_q);
        end
      end

      // allocation cleared by rst_i and on disable, set by the alloc ok event
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          aok_q <= 1'b0;
        end else if (!en_q) begin
          aok_q <= 1'b0;
        end else if (me && ev_alloc_ok_i) begin
          aok_q <= 1'b1;
        end
      end

      // flow flags and toggle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ovf_q <= 1'b0;
          udf_q <= 1'b0;
          tgl_q <= 1'b0;
        end else begin
          ovf_q <= (me & ev_overflow_i)
                   | (ovf_q & ~(wr & sw & hit(ofs, `UHP_OFS_STATE) & ~dat_i[6]));
          udf_q <= zlp | (udf_q & ~(wr & sw & hit(ofs, `UHP_OFS_STATE) & ~dat_i[5]));
          if (me && ev_toggle_i) begin
            tgl_q <= ev_toggle_val_i;
          end
        end
      end

      // in request countdown
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          in_request_count_field_q <= 8'h00;
        end else if (me && ev_in_done_i && !inf_q && in_request_count_field_q != 8'h00) begin
          in_request_count_field_q <= in_request_count_field_q - 8'h01;
        end else if (wr && sw && hit(ofs, `UHP_OFS_IN_REQUEST_COUNT_FIELD)) begin
          in_request_count_field_q <= dat_i[7:0];
        end
      end

      // error counter saturates at its freeze value
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ecnt_q <= 2'h0;
          err_q <= 5'h00;
        end else begin
          if (any_err && ecnt_q != `UHP_ERR_MAX) begin
            ecnt_q <= ecnt_q + 2'h1;
          end else if (wr && sw && hit(ofs, `UHP_OFS_ERR)) begin
            ecnt_q <= ecnt_q & dat_i[6:5];
          end
          err_q <= ({ev_crc_error_flag_i, ev_timeout_i, ev_pid_i, ev_data_pid_error_flag_i, ev_badtgl_i}
                    & {5{me}})
                   | (err_q & ~({5{wr & sw & hit(ofs, `UHP_OFS_ERR)}} & ~dat_i[4:0]));
        end
      end

      // bank handshake and busy banks
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          busy_q <= 2'h0;
          fcon_q <= 1'b0;
        end else begin
          if (me && ev_bank_filled_i && is_in && busy_q != `UHP_BUSY_MAX) begin
            busy_q <= busy_q + 2'h1;
          end else if (me && ev_bank_sent_i && is_out && busy_q != 2'h0) begin
            busy_q <= busy_q - 2'h1;
          end else if (fcon_clr) begin
            busy_q <= is_out ? busy_q + 2'h1 : busy_q - 2'h1;
          end
          if (me && ((ev_bank_sent_i && is_out) || (ev_bank_filled_i && is_in))) begin
            fcon_q <= 1'b1;
          end else if (fcon_clr) begin
            fcon_q <= 1'b0;
          end
        end
      end

      // event flags, hardware set wins over a software clear
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          nak_q <= 1'b0;
          stp_q <= 1'b0;
          out_q <= 1'b0;
          stl_q <= 1'b0;
          rxin_q <= 1'b0;
        end else begin
          nak_q <= (me & ev_nak_i) | (nak_q & ~(evt_wr & ~dat_i[`UHP_EV_NAK]));
          stp_q <= (me & ev_bank_sent_i & tok_q == uhp_pkg::UHP_SETUP)
                   | (stp_q & ~(evt_wr & ~dat_i[`UHP_EV_STP]));
          out_q <= (me & ev_bank_sent_i & tok_q == uhp_pkg::UHP_OUT)
                   | (out_q & ~(evt_wr & ~dat_i[`UHP_EV_OUT]));
          stl_q <= (me & (is_iso ? ev_crc_error_flag_i : ev_stall_i))
                   | (stl_q & ~(evt_wr & ~dat_i[`UHP_EV_STL]));
          rxin_q <= (me & ev_bank_filled_i & is_in)
                    | (rxin_q & ~(evt_wr & ~dat_i[`UHP_EV_RXIN]));
        end
      end

      // enables and byte counter
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ien_q <= 8'h00;
          bc_q <= 11'h000;
        end else begin
          if (wr && sw && hit(ofs, `UHP_OFS_IEN)) begin
            ien_q <= dat_i[7:0] & 8'hdf;
          end
          if ((pwr && is_out) || (me && ev_byte_rx_i && is_in)) begin
            bc_q <= bc_q + 11'h001;
          end else if ((prd && is_in && bc_q != 11'h000)
                       || (me && ev_byte_tx_i && is_out && bc_q != 11'h000)) begin
            bc_q <= bc_q - 11'h001;
          end
        end
      end

      // fifo accessible: room on OUT, data on IN, no stall or error pending
      assign rw_allowed = fcon_q & ~stl_q & ~perr
                    & (is_out ? (bc_q < 11'(MAX_BYTES)) : (bc_q != 11'h000));
      assign rd_ctl[g] = {1'b0, frz_q, inf_q, 4'h0, en_q};
      assign rd_cfg[g] = {typ_q, tok_q, 4'h0};
      assign rd_poll[g] = poll_q;
      assign rd_state[g] = {aok_q, ovf_q, udf_q, 1'b0, 1'b0, tgl_q, busy_q};
      assign rd_in_request_count_field[g] = in_request_count_field_q;
      assign rd_err[g] = {1'b0, ecnt_q, err_q};
      assign rd_evt[g] = {fcon_q, nak_q, rw_allowed, perr, stp_q, out_q, stl_q, rxin_q};
      assign rd_ien[g] = ien_q;
      assign rd_bc[g] = bc_q;
      // non-interrupt pipes get no polling bound
      assign poll_eff[g] = (typ_q == uhp_pkg::UHP_INTR) ? poll_q : 8'h00;
      assign zlp_w[g] = zlp;
      assign frz_w[g] = frz_q;
      // flow enable covers both flow flags; iso crc uses setup enable
      assign sum_w[g] = (ien_q[`UHP_IEN_FLOW] & (ovf_q | udf_q))
                        | (ien_q[`UHP_EV_NAK] & nak_q)
                        | (ien_q[`UHP_EV_PERR] & perr)
                        | (ien_q[`UHP_EV_STP] & stp_q)
                        | (ien_q[`UHP_EV_OUT] & out_q)
                        | (is_iso ? ien_q[`UHP_EV_STP] & stl_q
                                  : ien_q[`UHP_EV_STL] & stl_q)
                        | (ien_q[`UHP_EV_RXIN] & rxin_q);
    end
  endgenerate

  // ==========================================================
  // summary, fifo strobes and engine outputs
  logic [6:0] sum_q;
  logic zlp_q;
  logic [7:0] poll_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] wdat_q;
  logic [2:0] fpipe_q;
  logic valid_sel;
  assign valid_sel = (sel_pipe_q != 3'h7);

  // summary follows the flags, so servicing clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_q <= 7'h00;
      zlp_q <= 1'b0;
      poll_q <= 8'h00;
    end else begin
      sum_q <= sum_w;
      zlp_q <= |zlp_w;
      poll_q <= (evt_pipe_i != 3'h7) ? poll_eff[evt_pipe_i] : 8'h00;
    end
  end

  // one byte per data register access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      wdat_q <= 8'h00;
      fpipe_q <= 3'h0;
    end else begin
      wr_q <= wr & valid_sel & hit(ofs, `UHP_OFS_DATA);
      rd_q <= rd & valid_sel & hit(ofs, `UHP_OFS_DATA);
      fpipe_q <= sel_pipe_q;
      if (wr && hit(ofs, `UHP_OFS_DATA)) begin
        wdat_q <= dat_i[7:0];
      end
    end
  end
  assign fifo_wr_o = wr_q;
  assign fifo_rd_o = rd_q;
  assign fifo_wdata_o = wdat_q;
  assign fifo_pipe_o = fpipe_q;
  assign zlp_o = zlp_q;
  assign freeze_o = frz_w;
  assign poll_ms_o = poll_q;

  // ==========================================================
  // read mux, latched when the request is first seen
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    if (ofs == `UHP_OFS_PIPE_SEL) begin
      rmux = {5'h00, sel_pipe_q};
    end else if (ofs == `UHP_OFS_SUM) begin
      rmux = {1'b0, sum_q};
    end else if (valid_sel) begin
      unique case (ofs)
        `UHP_OFS_PIPE_CTL: rmux = rd_ctl[sel_pipe_q];
        `UHP_OFS_PIPE_CFG: rmux = rd_cfg[sel_pipe_q];
        `UHP_OFS_POLL: rmux = rd_poll[sel_pipe_q];
        `UHP_OFS_STATE: rmux = rd_state[sel_pipe_q];
        `UHP_OFS_IN_REQUEST_COUNT_FIELD: rmux = rd_in_request_count_field[sel_pipe_q];
        `UHP_OFS_ERR: rmux = rd_err[sel_pipe_q];
        `UHP_OFS_EVT: rmux = rd_evt[sel_pipe_q];
        `UHP_OFS_IEN: rmux = rd_ien[sel_pipe_q];
        `UHP_OFS_DATA: rmux = fifo_rdata_i;
        `UHP_OFS_BCH: rmux = {5'h00, rd_bc[sel_pipe_q][10:8]};
        `UHP_OFS_BCL: rmux = rd_bc[sel_pipe_q][7:0];
        default: rmux = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      dat_q <= {24'h00_0000, rmux};
    end
  end
endmodule

/* File: dv/uhp_pipe_status_properties.sv */
// concurrent properties on the ports of the pipe status block
`timescale 1ns/100ps
`include "uhp_defines.svh"
module uhp_pipe_status_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [2:0] evt_pipe_i,
  input wire logic ev_tx_req_i,
  input wire logic ev_stall_i,
  input wire logic fifo_wr_o,
  input wire logic fifo_rd_o,
  input wire logic [7:0] fifo_wdata_o,
  input wire logic zlp_o,
  input wire logic [6:0] freeze_o
);
  // ==========================================================
  // bus, fifo strobes and freeze
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // acked data register access, split by direction
  sequence s_data_ack;
    cyc_i && stb_i && ack_o && adr_i[7:2] == `UHP_OFS_DATA;
  endsequence
  sequence s_data_wr;
    s_data_ack ##0 (we_i && sel_i[0]);
  endsequence
  sequence s_data_rd;
    s_data_ack ##0 !we_i;
  endsequence
  property p_ack_wait;
    $rose(stb_i) && cyc_i |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_fifo_wr;
    s_data_wr |=> fifo_wr_o && fifo_wdata_o == $past(dat_i[7:0]);
  endproperty
  property p_fifo_rd;
    s_data_rd |=> fifo_rd_o;
  endproperty
  // a strobe with no acked access behind it would move a byte twice
  property p_strobe_cause;
    fifo_wr_o || fifo_rd_o |-> $past(ack_o) && !(fifo_wr_o && fifo_rd_o);
  endproperty
  property p_zlp_cause;
    zlp_o |-> $past(ev_tx_req_i);
  endproperty
  property p_stall_freeze;
    ev_stall_i && evt_pipe_i != 3'h7 |=> freeze_o[$past(evt_pipe_i)];
  endproperty
  property p_freeze_rst;
    $fell(rst_i) |-> freeze_o == 7'h7f;
  endproperty
  property p_dat_hi;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_fifo_wr: assert property (p_fifo_wr) else $error("no fifo write");
  a_fifo_rd: assert property (p_fifo_rd) else $error("no fifo read");
  a_strobe_cause: assert property (p_strobe_cause) else $error("stray strobe");
  a_zlp_cause: assert property (p_zlp_cause) else $error("stray zlp");
  a_stall_freeze: assert property (p_stall_freeze) else $error("no freeze");
  a_freeze_rst: assert property (p_freeze_rst) else $error("not frozen");
  a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
endmodule

bind uhp_pipe_status uhp_pipe_status_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .evt_pipe_i(evt_pipe_i),
  .ev_tx_req_i(ev_tx_req_i), .ev_stall_i(ev_stall_i), .fifo_wr_o(fifo_wr_o),
  .fifo_rd_o(fifo_rd_o), .fifo_wdata_o(fifo_wdata_o), .zlp_o(zlp_o), .freeze_o(freeze_o)
);

/* File: dv/uhp_usb_dev_model.sv */
// usb far side stand-in: engine event pulses and fifo bytes
`timescale 1ns/100ps
module uhp_usb_dev_model #(
  parameter logic [7:0] RD_BYTE = 8'h5a
) (
  input wire logic clk_i,
  output logic [2:0] pipe_o,
  output logic [15:0] ev_o,
  output logic tgl_val_o,
  output logic [7:0] rdata_o
);
  // ==========================================================
  // idle: no pulse, index parked on the ignored pipe
  initial begin
    pipe_o = 3'h7;
    ev_o = 16'h0;
    tgl_val_o = 1'h0;
  end
  // byte the fifo offers on a read
  assign rdata_o = RD_BYTE;
  // one pulse per call; index 16 only points at a pipe
  task automatic fire(input logic [2:0] p, input int k, input logic tv);
    @(posedge clk_i);
    pipe_o <= p;
    ev_o <= 16'h1 << k;
    tgl_val_o <= tv;
    @(posedge clk_i);
    pipe_o <= 3'h7;
    ev_o <= 16'h0;
    tgl_val_o <= ~tv;
  endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench of the pipe status block
`timescale 1ns/100ps
`include "uhp_defines.svh"
module tb;
  localparam logic [7:0] RD = 8'h5a;
  localparam int EV_ALLOC = 0, EV_OVF = 1, EV_TXREQ = 2, EV_TGL = 3, EV_FILL = 4;
  localparam int EV_SENT = 5, EV_INDONE = 6, EV_NAK = 7, EV_STALL = 8, EV_CRC = 9;
  localparam int EV_TMO = 10, EV_PID = 11, EV_DPID = 12, EV_BTGL = 13, EV_BRX = 14;
  localparam int EV_BTX = 15, EV_NONE = 16;
  logic clk_i, rst_i, cyc, stb, we, ack, tv, zlp;
  logic [7:0] adr, frd, poll;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [2:0] pipe, fpipe;
  logic [15:0] ev;
  logic [6:0] frz;
  int fails, checks;
  uhp_pipe_status #(.MAX_BYTES(64)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .evt_pipe_i(pipe),
    .ev_alloc_ok_i(ev[0]), .ev_overflow_i(ev[1]), .ev_tx_req_i(ev[2]), .ev_toggle_i(ev[3]),
    .ev_toggle_val_i(tv), .ev_bank_filled_i(ev[4]), .ev_bank_sent_i(ev[5]),
    .ev_in_done_i(ev[6]), .ev_nak_i(ev[7]), .ev_stall_i(ev[8]), .ev_crc_error_flag_i(ev[9]),
    .ev_timeout_i(ev[10]), .ev_pid_i(ev[11]), .ev_data_pid_error_flag_i(ev[12]), .ev_badtgl_i(ev[13]),
    .ev_byte_rx_i(ev[14]), .ev_byte_tx_i(ev[15]), .fifo_rdata_i(frd), .fifo_wr_o(),
    .fifo_rd_o(), .fifo_wdata_o(), .fifo_pipe_o(fpipe), .zlp_o(zlp), .freeze_o(frz),
    .poll_ms_o(poll)
  );
  uhp_usb_dev_model #(.RD_BYTE(RD)) dev (
    .clk_i(clk_i), .pipe_o(pipe), .ev_o(ev), .tgl_val_o(tv), .rdata_o(frd)
  );
  // ==========================================================
  // clock, verdict and bus helpers
  always #4 clk_i = ~clk_i;
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // classic cycle held until ack; bounded so a dead slave ends the run
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {a, 2'h0};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 16);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    if (ack !== 1'h1) begin
      fails++;
      $display("wrong value ack exp 1 got %b", ack);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic rc(input string n, input logic [5:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] q;
    wb(1'h0, a, 8'h0, q);
    chk(n, e, q & m);
  endtask
  task automatic open_pipe(input logic [2:0] p, input logic [7:0] cfg);
    wr(`UHP_OFS_PIPE_SEL, {5'h0, p});
    wr(`UHP_OFS_PIPE_CFG, cfg);
    wr(`UHP_OFS_PIPE_CTL, 8'h01);
    dev.fire(p, EV_ALLOC, 1'h0);
    wr(`UHP_OFS_PIPE_CTL, 8'h01);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc("in_request_count_field", `UHP_OFS_IN_REQUEST_COUNT_FIELD, 8'hff, 8'h00);
    rc("bcl", `UHP_OFS_BCL, 8'hff, 8'h00);
    rc("sum", `UHP_OFS_SUM, 8'hff, 8'h00);
    rc("unmapped", 6'h20, 8'hff, 8'h00);
    wr(`UHP_OFS_PIPE_SEL, 8'h07);
    wr(`UHP_OFS_POLL, 8'h33);
    rc("pipe7", `UHP_OFS_POLL, 8'hff, 8'h00);
  endtask
  task automatic t_poll();
    open_pipe(3'h1, 8'h00);
    wr(`UHP_OFS_POLL, 8'h55);
    open_pipe(3'h2, 8'he0);
    wr(`UHP_OFS_POLL, 8'h20);
    rc("alloc", `UHP_OFS_STATE, 8'h80, 8'h80);
    chk("frz2", 8'h00, {7'h0, frz[2]});
    dev.fire(3'h2, EV_NONE, 1'h0);
    #1 chk("poll2", 8'h20, poll);
    dev.fire(3'h1, EV_NONE, 1'h0);
    #1 chk("poll1", 8'h00, poll);
  endtask
  task automatic t_errors();
    dev.fire(3'h2, EV_CRC, 1'h0);
    dev.fire(3'h2, EV_TMO, 1'h0);
    dev.fire(3'h2, EV_PID, 1'h0);
    rc("err", `UHP_OFS_ERR, 8'hff, 8'h7c);
    chk("frz_err", 8'h01, {7'h0, frz[2]});
    rc("perr", `UHP_OFS_EVT, 8'h10, 8'h10);
    wr(`UHP_OFS_ERR, 8'hff);
    rc("err_w1", `UHP_OFS_ERR, 8'hff, 8'h7c);
    wr(`UHP_OFS_ERR, 8'h00);
    rc("perr_clr", `UHP_OFS_EVT, 8'h10, 8'h00);
    dev.fire(3'h2, EV_DPID, 1'h0);
    dev.fire(3'h2, EV_BTGL, 1'h0);
    rc("err2", `UHP_OFS_ERR, 8'hff, 8'h43);
    wr(`UHP_OFS_ERR, 8'h00);
    dev.fire(3'h2, EV_OVF, 1'h0);
    wr(`UHP_OFS_IEN, 8'h80);
    rc("sum_ovf", `UHP_OFS_SUM, 8'hff, 8'h04);
    wr(`UHP_OFS_STATE, 8'hbf);
    rc("ovf_clr", `UHP_OFS_STATE, 8'h40, 8'h00);
    rc("sum_clr", `UHP_OFS_SUM, 8'hff, 8'h00);
    wr(`UHP_OFS_PIPE_CTL, 8'h01);
  endtask
  // each flag first masked, then enabled, then cleared
  task automatic t_events();
    int ks[2] = '{EV_NAK, EV_STALL};
    logic [7:0] ms[2] = '{8'h40, 8'h02};
    for (int i = 0; i < 2; i++) begin
      wr(`UHP_OFS_IEN, 8'h00);
      dev.fire(3'h2, ks[i], 1'h0);
      rc("sum_off", `UHP_OFS_SUM, 8'hff, 8'h00);
      rc("flag", `UHP_OFS_EVT, ms[i], ms[i]);
      wr(`UHP_OFS_IEN, ms[i]);
      rc("sum_on", `UHP_OFS_SUM, 8'hff, 8'h04);
      wr(`UHP_OFS_EVT, ~ms[i]);
      rc("sum_srv", `UHP_OFS_SUM, 8'hff, 8'h00);
    end
    chk("frz_stall", 8'h01, {7'h0, frz[2]});
    wr(`UHP_OFS_PIPE_CTL, 8'h01);
  endtask
  task automatic t_fifo_out();
    for (int i = 0; i < 3; i++) begin
      wr(`UHP_OFS_DATA, 8'h10 + i[7:0]);
    end
    rc("bcl_out", `UHP_OFS_BCL, 8'hff, 8'h03);
    dev.fire(3'h2, EV_BTX, 1'h0);
    rc("bcl_tx", `UHP_OFS_BCL, 8'hff, 8'h02);
    rc("bch", `UHP_OFS_BCH, 8'hff, 8'h00);
    dev.fire(3'h2, EV_SENT, 1'h0);
    wr(`UHP_OFS_EVT, 8'h7b);
    rc("busy1", `UHP_OFS_STATE, 8'h03, 8'h01);
    wr(`UHP_OFS_IEN, 8'h04);
    dev.fire(3'h2, EV_SENT, 1'h0);
    rc("busy0", `UHP_OFS_STATE, 8'h03, 8'h00);
    rc("bank_free", `UHP_OFS_EVT, 8'h84, 8'h84);
    rc("sum_out", `UHP_OFS_SUM, 8'hff, 8'h04);
    wr(`UHP_OFS_EVT, 8'hfb);
    wr(`UHP_OFS_IEN, 8'h00);
    dev.fire(3'h2, EV_TGL, 1'h1);
    rc("toggle", `UHP_OFS_STATE, 8'h0c, 8'h04);
    dev.fire(3'h2, EV_TXREQ, 1'h0);
    #1 chk("zlp", 8'h01, {7'h0, zlp});
    rc("udf", `UHP_OFS_STATE, 8'h20, 8'h20);
  endtask
  task automatic t_in();
    open_pipe(3'h3, 8'h90);
    wr(`UHP_OFS_IN_REQUEST_COUNT_FIELD, 8'h01);
    dev.fire(3'h3, EV_INDONE, 1'h0);
    rc("in_request_count_field_dec", `UHP_OFS_IN_REQUEST_COUNT_FIELD, 8'hff, 8'h00);
    chk("frz_in1", 8'h00, {7'h0, frz[3]});
    dev.fire(3'h3, EV_INDONE, 1'h0);
    #1 chk("frz_in2", 8'h01, {7'h0, frz[3]});
    wr(`UHP_OFS_PIPE_CTL, 8'h21);
    dev.fire(3'h3, EV_INDONE, 1'h0);
    #1 chk("frz_inf", 8'h00, {7'h0, frz[3]});
    wr(`UHP_OFS_IEN, 8'h01);
    dev.fire(3'h3, EV_FILL, 1'h0);
    rc("rx_in", `UHP_OFS_EVT, 8'h81, 8'h81);
    rc("sum_in", `UHP_OFS_SUM, 8'hff, 8'h08);
    rc("busy_in", `UHP_OFS_STATE, 8'h03, 8'h01);
    dev.fire(3'h3, EV_BRX, 1'h0);
    dev.fire(3'h3, EV_BRX, 1'h0);
    rc("rd", `UHP_OFS_DATA, 8'hff, RD);
    rc("bcl_in", `UHP_OFS_BCL, 8'hff, 8'h01);
    rc("rw_allowed", `UHP_OFS_EVT, 8'h20, 8'h20);
    chk("fpipe", 8'h03, {5'h0, fpipe});
    wr(`UHP_OFS_EVT, 8'h7e);
    rc("busy_in0", `UHP_OFS_STATE, 8'h03, 8'h00);
    wr(`UHP_OFS_PIPE_CTL, 8'h00);
    rc("alloc_off", `UHP_OFS_STATE, 8'h80, 8'h00);
    open_pipe(3'h4, 8'h60);
    wr(`UHP_OFS_IEN, 8'h08);
    dev.fire(3'h4, EV_CRC, 1'h0);
    rc("iso_crc", `UHP_OFS_SUM, 8'hff, 8'h10);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    sel = 4'hf;
    adr = 8'h00;
    wdat = 32'h0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_poll();
    t_errors();
    t_events();
    t_fifo_out();
    t_in();
    tally_and_finish();
  end
endmodule
